// >>> shared/lsf_pkg.sv
// Line status flag block: register map, field positions and timing constants
package lsf_pkg;
  // Register offsets on the local port
  localparam logic [2:0] RX_BUF_OFS = 3'h0;
  localparam logic [2:0] IEN_OFS    = 3'h1;
  localparam logic [2:0] CTRL_OFS   = 3'h3;
  localparam logic [2:0] LSR_OFS    = 3'h5;
  // Line condition status bit positions
  localparam int DR_BIT   = 0;
  localparam int OE_BIT   = 1;
  localparam int PE_BIT   = 2;
  localparam int FE_BIT   = 3;
  localparam int BI_BIT   = 4;
  localparam int TX_HOLDING_VACANT_BIT = 5;
  localparam int TEMT_BIT = 6;
  localparam int FERR_BIT = 7;
  // Control register fields
  localparam int CTL_FIFO_BIT = 0;
  localparam int CTL_DLEN_LSB = 1;
  localparam int CTL_STOP_BIT = 3;
  localparam int CTL_PEN_BIT  = 4;
  localparam int CTL_EVEN_BIT = 5;
  // Interrupt enable fields
  localparam int IEN_TX_HOLDING_VACANT_BIT = 0;
  localparam int IEN_RLS_BIT  = 1;
  // Queue entry layout: data in the low byte, then error marks
  localparam int ENT_PE = 8;
  localparam int ENT_FE = 9;
  localparam int ENT_BI = 10;
  localparam int ENT_W  = 11;
  // Reset values
  localparam logic [7:0] LSR_RST  = 8'h00;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [1:0] IEN_RST  = 2'h0;
  // Oversampling: ticks per bit and the half-bit idle before restart
  localparam logic [7:0] TICKS_PER_BIT  = 8'h10;
  localparam logic [7:0] HALF_BIT_TICKS = 8'h08;
  localparam logic [3:0] MIN_DATA_BITS  = 4'h5;
endpackage

// >>> design/lsf_rx_mem.sv
// Receive queue storage with registered read data
module lsf_rx_mem #(
  parameter int W  = 11,
  parameter int AW = 4
) (
  // Clock
  input  wire logic          i_clk,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  // Read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata
);
  logic [W-1:0] mem [2**AW];

  // Storage has no reset; the pointers decide what is valid
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read data always come out of a register
  always_ff @(posedge i_clk) begin
    o_rdata <= mem[i_raddr];
  end
endmodule // lsf_rx_mem

// >>> design/lsf_break_watch.sv
// Break detector on the serial input with half-bit restart guard
module lsf_break_watch (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // Line and timing
  input  wire logic       i_tick,
  input  wire logic       i_rxd,
  input  wire logic [7:0] i_char_ticks,
  // Results
  output logic            o_break,
  output logic            o_rx_ok
);
  typedef enum logic [1:0] {
    LSF_WATCH  = 2'b01,
    LSF_BROKEN = 2'b10
  } lsf_bw_t;

  lsf_bw_t    state;
  logic [7:0] cnt;

  // Low time is counted in oversample ticks; one pulse per break
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state   <= LSF_WATCH;
      cnt     <= 8'h00;
      o_break <= 1'b0;
    end else begin
      o_break <= 1'b0;
      unique case (state)
        LSF_WATCH: begin
          if (i_rxd) begin
            cnt <= 8'h00;
          end else if (i_tick) begin
            if (cnt >= i_char_ticks) begin
              state   <= LSF_BROKEN;
              o_break <= 1'b1;
              cnt     <= 8'h00;
            end else begin
              cnt <= cnt + 8'h01;
            end
          end
        end
        LSF_BROKEN: begin
          if (!i_rxd) begin
            cnt <= 8'h00;
          end else if (i_tick) begin
            if (cnt >= lsf_pkg::HALF_BIT_TICKS - 8'h01) begin
              state <= LSF_WATCH;
              cnt   <= 8'h00;
            end else begin
              cnt <= cnt + 8'h01;
            end
          end
        end
      endcase
    end
  end

  // Reception is held off until the line has idled half a bit
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rx_ok <= 1'b1;
    end else begin
      o_rx_ok <= (state == LSF_WATCH) && !(i_tick && !i_rxd && cnt >= i_char_ticks);
    end
  end
endmodule // lsf_break_watch

// >>> design/lsf_line_status.sv
// Line condition status logic: receive errors, queue tracking, transmit empties
// Notes on behaviour
// - Non-FIFO mode: bit 7 always reads zero
// - FIFO mode: bit 7 tracks queued errored characters
// - Bit 6 set when holding and shift empty
// - Bit 5 set on shift load, cleared on write
// - Transmit interrupt when bit 5 and enabled
// - FIFO mode: bit 5 means transmit queue empty
// - Bit 4 set after low for character time
// - Status read clears the break flag
// - One zero character queued per break
// - Restart only after half-bit high idle
// - FIFO errors shown when character reaches head
// - Line status interrupt on bits 1-4, enabled
// - Bit 3 set on zero stop bit; read clears
// - After framing error, resync on low level
// - Bit 2 set on parity mismatch; read clears
// - Non-FIFO: overrun when unread buffer is replaced
// - FIFO: overrun only when full; character dropped
// - Overrun set at once, read clears
// - Bit 0 set on arrival, cleared when drained
module lsf_line_status #(
  parameter int RX_AW    = 4,
  parameter int TX_DEPTH = 16
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // Register port
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Receive character from the deserializer
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  input  wire logic       i_rx_parity,
  input  wire logic       i_rx_stop,
  // Serial input and oversample tick
  input  wire logic       i_rxd,
  input  wire logic       i_os_tick,
  // Transmitter side
  input  wire logic       i_tx_load,
  input  wire logic       i_tx_shift_busy,
  output logic            o_tx_wr,
  output logic      [7:0] o_tx_wdata,
  // Receiver control and interrupts
  output logic            o_rx_enable,
  output logic            o_rx_resync,
  output logic            o_tx_int,
  output logic            o_rls_int
);
  localparam int RX_CW = RX_AW + 1;
  localparam int TX_CW = $clog2(TX_DEPTH + 1);

  logic [5:0]       ctrl;
  logic [1:0]       ien;
  logic [7:0]       line_condition_status;
  logic             flag_dr;
  logic             flag_oe;
  logic             flag_pe;
  logic             flag_fe;
  logic             flag_brk;
  logic             flag_vacant;
  logic             flag_idle;
  logic             flag_sum;
  logic [RX_AW-1:0] wr_ptr;
  logic [RX_AW-1:0] rd_ptr;
  logic [RX_CW-1:0] rx_cnt;
  logic [TX_CW-1:0] tx_cnt;
  logic [2**RX_AW-1:0] err_vec;
  logic [1:0]       hd_pipe;
  logic [7:0]       char_ticks;
  logic [lsf_pkg::ENT_W-1:0] head_q;
  logic [lsf_pkg::ENT_W-1:0] wr_ent;
  logic             brk_pulse;
  logic             rx_ok;

  // Access decode; a status read is a single-cycle clear pulse
  logic lsr_rd;
  logic pop;
  logic thr_wr;
  assign lsr_rd = i_rd && (i_addr == lsf_pkg::LSR_OFS);
  assign pop    = i_rd && (i_addr == lsf_pkg::RX_BUF_OFS) && (rx_cnt != '0);
  assign thr_wr = i_wr && (i_addr == lsf_pkg::RX_BUF_OFS);

  // Control fields
  logic       fifo_md;
  logic [3:0] dbits;
  logic       pen;
  logic       even;
  assign fifo_md = ctrl[lsf_pkg::CTL_FIFO_BIT];
  assign dbits   = lsf_pkg::MIN_DATA_BITS + {2'b00, ctrl[lsf_pkg::CTL_DLEN_LSB +: 2]};
  assign pen     = ctrl[lsf_pkg::CTL_PEN_BIT];
  assign even    = ctrl[lsf_pkg::CTL_EVEN_BIT];

  // Software-written control and enables
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl <= lsf_pkg::CTRL_RST;
      ien  <= lsf_pkg::IEN_RST;
    end else if (i_wr) begin
      if (i_addr == lsf_pkg::CTRL_OFS) begin
        ctrl <= i_wdata[5:0];
      end
      if (i_addr == lsf_pkg::IEN_OFS) begin
        ien <= i_wdata[1:0];
      end
    end
  end

  // Full character time: start + data + parity + stop bits, in ticks
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      char_ticks <= 8'h00;
    end else begin
      char_ticks <= 8'({4'h0, 4'h1 + dbits + {3'b000, pen} + {3'b000, ctrl[3]} + 4'h1}
                    * lsf_pkg::TICKS_PER_BIT);
    end
  end

  lsf_break_watch u_brk (
    .i_clk        (i_clk),
    .i_rstn       (i_rstn),
    .i_tick       (i_os_tick),
    .i_rxd        (i_rxd),
    .i_char_ticks (char_ticks),
    .o_break      (brk_pulse),
    .o_rx_ok      (rx_ok)
  );

  // Parity over the active data bits only
  function automatic logic par_bad(input logic [7:0] d, input logic [3:0] n, input logic p,
                                   input logic ev);
    logic [7:0] m;
    m = d & 8'(8'hff >> (4'h8 - n));
    return ev ? (^{m, p}) : !(^{m, p});
  endfunction

  // Incoming entry; a break queues one all-zero character
  logic push;
  logic rx_pe;
  logic rx_fe;
  always_comb begin
    rx_pe  = pen && par_bad(i_rx_data, dbits, i_rx_parity, even);
    rx_fe  = !i_rx_stop;
    wr_ent = '0;
    if (brk_pulse) begin
      wr_ent[lsf_pkg::ENT_BI] = 1'b1;
    end else begin
      wr_ent[7:0]             = i_rx_data;
      wr_ent[lsf_pkg::ENT_PE] = rx_pe;
      wr_ent[lsf_pkg::ENT_FE] = rx_fe;
    end
  end
  assign push = brk_pulse || (i_rx_valid && rx_ok);

  // Queue bookkeeping; the single buffer of non-FIFO mode is slot zero
  logic full;
  logic do_write;
  logic inc;
  logic ovr_set;
  logic wr_err;
  logic [RX_AW-1:0] waddr;
  logic [RX_AW-1:0] raddr;
  assign full     = fifo_md ? (rx_cnt == RX_CW'(2**RX_AW)) : (rx_cnt != '0);
  assign do_write = push && (!fifo_md || !full);
  assign inc      = fifo_md ? do_write : (push && (rx_cnt == '0 || pop));
  assign ovr_set  = push && full && (fifo_md || !pop);
  assign wr_err   = wr_ent[lsf_pkg::ENT_PE] | wr_ent[lsf_pkg::ENT_FE] | wr_ent[lsf_pkg::ENT_BI];
  assign waddr    = fifo_md ? wr_ptr : '0;
  assign raddr    = fifo_md ? rd_ptr : '0;

  lsf_rx_mem #(.W(lsf_pkg::ENT_W), .AW(RX_AW)) u_mem (
    .i_clk   (i_clk),
    .i_we    (do_write),
    .i_waddr (waddr),
    .i_wdata (wr_ent),
    .i_raddr (raddr),
    .o_rdata (head_q)
  );

  // Pointers, fill count and the two-cycle wait for a new head to read out
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      rx_cnt  <= '0;
      hd_pipe <= 2'b00;
    end else begin
      if (do_write && fifo_md) begin
        wr_ptr <= wr_ptr + RX_AW'(1);
      end
      if (pop && fifo_md) begin
        rd_ptr <= rd_ptr + RX_AW'(1);
      end
      rx_cnt  <= rx_cnt + RX_CW'(inc) - RX_CW'(pop);
      hd_pipe <= {hd_pipe[0], fifo_md && ((do_write && rx_cnt == '0) || (pop && rx_cnt > 1))};
    end
  end

  // Error marks of each queued entry, for the summary flag
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      err_vec <= '0;
    end else if (!fifo_md) begin
      err_vec <= '0;
    end else begin
      if (pop) begin
        err_vec[rd_ptr] <= 1'b0;
      end
      if (do_write) begin
        err_vec[wr_ptr] <= wr_err;
      end
    end
  end

  // Errors to flag: direct in non-FIFO mode, at the queue head in FIFO mode
  logic set_pe;
  logic set_fe;
  logic set_bi;
  assign set_pe = fifo_md ? (hd_pipe[1] && head_q[lsf_pkg::ENT_PE])
                          : (do_write && wr_ent[lsf_pkg::ENT_PE]);
  assign set_fe = fifo_md ? (hd_pipe[1] && head_q[lsf_pkg::ENT_FE])
                          : (do_write && wr_ent[lsf_pkg::ENT_FE]);
  assign set_bi = fifo_md ? (hd_pipe[1] && head_q[lsf_pkg::ENT_BI])
                          : (do_write && wr_ent[lsf_pkg::ENT_BI]);

  // Sticky receive flags; a new event in the clearing cycle wins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_oe  <= 1'b0;
      flag_pe  <= 1'b0;
      flag_fe  <= 1'b0;
      flag_brk <= 1'b0;
    end else begin
      flag_oe  <= ovr_set || (flag_oe && !lsr_rd);
      flag_pe  <= set_pe || (flag_pe && !lsr_rd);
      flag_fe  <= set_fe || (flag_fe && !lsr_rd);
      flag_brk <= set_bi || (flag_brk && !lsr_rd);
    end
  end

  // Status byte is assembled from flags, each kept by one process only
  assign line_condition_status = {flag_sum, flag_idle, flag_vacant, flag_brk, flag_fe, flag_pe, flag_oe, flag_dr};

  // Data ready follows the fill count; error summary only in FIFO mode
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_dr  <= 1'b0;
      flag_sum <= 1'b0;
    end else begin
      flag_dr  <= (rx_cnt + RX_CW'(inc) - RX_CW'(pop)) != '0;
      flag_sum <= fifo_md && ((do_write && wr_err) ||
                  (flag_sum && !(lsr_rd && err_vec == '0)));
    end
  end

  // Transmit occupancy: one holding slot, or the queue in FIFO mode
  logic [TX_CW-1:0] tx_next;
  logic [TX_CW-1:0] tx_cap;
  assign tx_cap  = fifo_md ? TX_CW'(TX_DEPTH) : TX_CW'(1);
  always_comb begin
    tx_next = tx_cnt;
    if (i_tx_load && tx_cnt != '0) begin
      tx_next = tx_next - TX_CW'(1);
    end
    if (thr_wr && tx_next < tx_cap) begin
      tx_next = tx_next + TX_CW'(1);
    end
  end

  // Holding empty and transmitter idle flags; write data forwarded one cycle later
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_cnt                 <= '0;
      flag_vacant            <= 1'b0;
      flag_idle              <= 1'b0;
      o_tx_wr                <= 1'b0;
      o_tx_wdata             <= 8'h00;
    end else begin
      tx_cnt                 <= tx_next;
      flag_vacant            <= tx_next == '0;
      flag_idle              <= (tx_next == '0) && !i_tx_shift_busy;
      o_tx_wr                <= thr_wr;
      o_tx_wdata             <= i_wdata;
    end
  end

  // Interrupts, receiver enable and resync request
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_int    <= 1'b0;
      o_rls_int   <= 1'b0;
      o_rx_enable <= 1'b1;
      o_rx_resync <= 1'b0;
    end else begin
      o_tx_int    <= line_condition_status[lsf_pkg::TX_HOLDING_VACANT_BIT] && ien[lsf_pkg::IEN_TX_HOLDING_VACANT_BIT];
      o_rls_int   <= (|line_condition_status[lsf_pkg::BI_BIT:lsf_pkg::OE_BIT]) && ien[lsf_pkg::IEN_RLS_BIT];
      o_rx_enable <= rx_ok;
      o_rx_resync <= i_rx_valid && rx_ok && rx_fe;
    end
  end

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= lsf_pkg::LSR_RST;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      unique case (i_addr)
        lsf_pkg::RX_BUF_OFS: o_rdata <= head_q[7:0];
        lsf_pkg::IEN_OFS:    o_rdata <= {6'h00, ien};
        lsf_pkg::CTRL_OFS:   o_rdata <= {2'b00, ctrl};
        lsf_pkg::LSR_OFS:    o_rdata <= line_condition_status;
        default:             o_rdata <= 8'h00;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_err_char;
    do_write && wr_err && fifo_md;
  endsequence
  sequence s_flag_read;
    lsr_rd && !ovr_set;
  endsequence

  property p_ferr_off;
    !fifo_md |=> !line_condition_status[lsf_pkg::FERR_BIT];
  endproperty
  a_ferr_off: assert property (p_ferr_off) else $error("summary set outside FIFO mode");
  property p_ferr_set;
    s_err_char |=> line_condition_status[lsf_pkg::FERR_BIT];
  endproperty
  a_ferr_set: assert property (p_ferr_set) else $error("summary missed errored entry");
  property p_temt;
    $rose(line_condition_status[lsf_pkg::TEMT_BIT]) |-> line_condition_status[lsf_pkg::TX_HOLDING_VACANT_BIT] && $past(!i_tx_shift_busy);
  endproperty
  a_temt: assert property (p_temt) else $error("idle flag while data held");
  property p_tx_holding_vacant_clr;
    thr_wr |=> !line_condition_status[lsf_pkg::TX_HOLDING_VACANT_BIT];
  endproperty
  a_tx_holding_vacant_clr: assert property (p_tx_holding_vacant_clr) else $error("holding flag kept after write");
  property p_tx_int;
    line_condition_status[lsf_pkg::TX_HOLDING_VACANT_BIT] && ien[lsf_pkg::IEN_TX_HOLDING_VACANT_BIT] |=> o_tx_int;
  endproperty
  a_tx_int: assert property (p_tx_int) else $error("transmit interrupt missing");
  property p_rls_int;
    (|line_condition_status[lsf_pkg::BI_BIT:lsf_pkg::OE_BIT]) && ien[lsf_pkg::IEN_RLS_BIT] |=> o_rls_int;
  endproperty
  a_rls_int: assert property (p_rls_int) else $error("line status interrupt missing");
  property p_ovr_clr;
    s_flag_read |=> !line_condition_status[lsf_pkg::OE_BIT];
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared by read");
  property p_set_wins;
    ovr_set |=> line_condition_status[lsf_pkg::OE_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("overrun event lost");
  property p_dr;
    do_write |=> line_condition_status[lsf_pkg::DR_BIT];
  endproperty
  a_dr: assert property (p_dr) else $error("data ready not set");
  property p_full_drop;
    fifo_md && push && full && !pop |=> $stable(rx_cnt);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("character queued while full");
endmodule // lsf_line_status

// >>> bench/lsf_remote_model.sv
// Far side model: serial line level, oversample tick and transmit shifter drain
module lsf_remote_model #(
  parameter int TICK_DIV  = 4,
  parameter int SHIFT_CYC = 20
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // Bench controls
  input  wire logic i_space,
  input  wire logic i_hold,
  input  wire logic i_tx_wr,
  // Towards the block
  output logic      o_os_tick,
  output logic      o_rxd,
  output logic      o_tx_load,
  output logic      o_tx_shift_busy
);
  int   div;
  int   pend;
  int   shift;
  logic go;

  // Tick every few cycles; line rests at mark unless the bench asks for spacing
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div       <= 0;
      o_os_tick <= 1'b0;
      o_rxd     <= 1'b1;
    end else begin
      div       <= (div == TICK_DIV - 1) ? 0 : div + 1;
      o_os_tick <= (div == 0);
      o_rxd     <= !i_space;
    end
  end

  // Shifter takes a character only when idle; hold lets the bench stall it
  assign go = (pend > 0) && (shift == 0) && !i_hold && !o_tx_load;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend      <= 0;
      shift     <= 0;
      o_tx_load <= 1'b0;
    end else begin
      o_tx_load <= go;
      shift     <= go ? SHIFT_CYC : (shift > 0 ? shift - 1 : 0);
      pend      <= pend + (i_tx_wr ? 1 : 0) - (go ? 1 : 0);
    end
  end
  assign o_tx_shift_busy = (shift > 0);
endmodule // lsf_remote_model

// >>> bench/lsf_line_status_tb_top.sv
// Self-checking bench for the line status block
module lsf_line_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] LS = lsf_pkg::LSR_OFS;
  localparam logic [2:0] RB = lsf_pkg::RX_BUF_OFS;
  localparam logic [2:0] IE = lsf_pkg::IEN_OFS;
  localparam logic [2:0] CT = lsf_pkg::CTRL_OFS;
  logic       i_clk = 1'b0;
  logic       i_rstn = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       i_rx_valid = 1'b0;
  logic [7:0] i_rx_data = 8'h00;
  logic       i_rx_parity = 1'b0;
  logic       i_rx_stop = 1'b1;
  logic       space = 1'b0;
  logic       hold = 1'b0;
  logic [7:0] o_rdata;
  logic [7:0] o_tx_wdata;
  logic       o_tx_wr, o_rx_enable, o_rx_resync, o_tx_int, o_rls_int;
  logic       os_tick, rxd, tx_load, tx_busy;
  int         errors = 0;
  int         check_count = 0;

  // 250 MHz clock
  always #2 i_clk = ~i_clk;

  lsf_line_status lsf_line_status_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data), .i_rx_parity(i_rx_parity), .i_rx_stop(i_rx_stop),
    .i_rxd(rxd), .i_os_tick(os_tick), .i_tx_load(tx_load),
    .i_tx_shift_busy(tx_busy), .o_tx_wr(o_tx_wr), .o_tx_wdata(o_tx_wdata),
    .o_rx_enable(o_rx_enable), .o_rx_resync(o_rx_resync),
    .o_tx_int(o_tx_int), .o_rls_int(o_rls_int));

  lsf_remote_model lsf_remote_model_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_space(space), .i_hold(hold),
    .i_tx_wr(o_tx_wr), .o_os_tick(os_tick), .o_rxd(rxd),
    .o_tx_load(tx_load), .o_tx_shift_busy(tx_busy));

  task automatic end_of_test();
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  task automatic rxc(input logic [7:0] d, input logic p, input logic s);
    @(posedge i_clk);
    i_rx_valid  <= 1'b1;
    i_rx_data   <= d;
    i_rx_parity <= p;
    i_rx_stop   <= s;
    @(posedge i_clk);
    i_rx_valid  <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge os_tick);
  endtask

  // Watchdog: the sequence needs about 1500 cycles
  initial begin
    #60us;
    errors++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk);
    rdc(LS, 8'h60);
    rdc(3'h2, 8'h00);
    wr(LS, 8'hff);
    rdc(LS, 8'h60);
    wr(IE, 8'h03);
    // Non-FIFO framing error; bit 7 must stay low
    rxc(8'h15, 1'b0, 1'b0);
    #1 chk1(o_rx_resync, 1'b1);
    @(posedge i_clk);
    #1 chk1(o_rls_int, 1'b1);
    rdc(LS, 8'h69);
    rdc(LS, 8'h61);
    chk1(o_rls_int, 1'b0);
    rdc(RB, 8'h15);
    rdc(LS, 8'h60);
    // Parity error lands in the same cycle as a status read: the set must win
    wr(CT, 8'h30);
    fork
      rxc(8'h01, 1'b0, 1'b1);
      rdc(LS, 8'h60);
    join
    rdc(LS, 8'h65);
    rxc(8'h03, 1'b0, 1'b1);
    rdc(LS, 8'h63);
    rdc(RB, 8'h03);
    rdc(LS, 8'h60);
    // Transmit holding and shifter empties, with the shifter stalled first
    @(posedge i_clk);
    hold <= 1'b1;
    wr(RB, 8'h5a);
    #1 chk1(o_tx_wr, 1'b1);
    chk(o_tx_wdata, 8'h5a);
    rdc(LS, 8'h00);
    chk1(o_tx_int, 1'b0);
    hold <= 1'b0;
    repeat (3) @(posedge i_clk);
    rdc(LS, 8'h20);
    chk1(o_tx_int, 1'b1);
    wr(IE, 8'h02);
    @(posedge i_clk);
    #1 chk1(o_tx_int, 1'b0);
    repeat (25) @(posedge i_clk);
    rdc(LS, 8'h60);
    // Break: 5 data bits, no parity, one stop gives 112 ticks of character time
    wr(CT, 8'h00);
    @(posedge i_clk);
    space <= 1'b1;
    wt(100);
    rdc(LS, 8'h60);
    wt(20);
    chk1(o_rls_int, 1'b1);
    chk1(o_rx_enable, 1'b0);
    rdc(LS, 8'h71);
    rdc(LS, 8'h61);
    wt(150);
    @(posedge i_clk);
    space <= 1'b0;
    wt(4);
    chk1(o_rx_enable, 1'b0);
    rxc(8'h07, 1'b0, 1'b1);
    wt(8);
    chk1(o_rx_enable, 1'b1);
    rdc(RB, 8'h00);
    rdc(LS, 8'h60);
    // FIFO mode: errors travel with their own character
    wr(CT, 8'h01);
    rxc(8'h01, 1'b0, 1'b1);
    rxc(8'h02, 1'b0, 1'b0);
    rxc(8'h03, 1'b0, 1'b1);
    repeat (4) @(posedge i_clk);
    rdc(LS, 8'he1);
    rdc(RB, 8'h01);
    repeat (4) @(posedge i_clk);
    rdc(LS, 8'he9);
    rdc(RB, 8'h02);
    repeat (4) @(posedge i_clk);
    rdc(LS, 8'he1);
    rdc(LS, 8'h61);
    rdc(RB, 8'h03);
    rdc(LS, 8'h60);
    // Fill the queue past full; the seventeenth character is dropped
    for (int i = 0; i < 17; i++) begin
      rxc(i[7:0], 1'b0, 1'b1);
    end
    repeat (4) @(posedge i_clk);
    rdc(LS, 8'h63);
    for (int i = 0; i < 16; i++) begin
      repeat (2) @(posedge i_clk);
      rdc(RB, i[7:0]);
    end
    repeat (4) @(posedge i_clk);
    rdc(LS, 8'h60);
    // FIFO transmit: holding empty means the whole queue is empty
    @(posedge i_clk);
    hold <= 1'b1;
    wr(RB, 8'ha1);
    wr(RB, 8'ha2);
    rdc(LS, 8'h00);
    hold <= 1'b0;
    repeat (4) @(posedge i_clk);
    rdc(LS, 8'h00);
    repeat (60) @(posedge i_clk);
    rdc(LS, 8'h60);
    end_of_test();
  end
endmodule // lsf_line_status_tb_top
